// ### rtl/sthc_link.sv
`timescale 1ns/1ps
module sthc_link (
    // link clock and reset
    input  wire logic                        serial_bit_clk,
    input  wire logic                        rst_n,
    // link pins
    input  wire logic                        serial_in_tap,
    input  wire logic                        board_data_addr_sel,
    input  wire logic                        controller_slot_sel_n,
    output logic                             serial_out_tap,
    output logic                             serial_out_tap_oe,
    // system side
    input  wire logic                        connect,
    input  wire logic [sthc_pkg::DATA_W-1:0] readback,
    output logic      [sthc_pkg::DATA_W-1:0] word,
    output logic                             word_is_addr,
    output logic                             word_toggle
);
    import sthc_pkg::*;

    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] tx;
    logic [2:0]        bit_cnt;
    sthc_phase_type    phase;
    logic              connect_meta;
    logic              connect_sync;

    // connection option crosses as a level
    always_ff @(posedge serial_bit_clk or negedge rst_n) begin
        if (!rst_n) begin
            connect_meta <= 1'b0;
            connect_sync <= 1'b0;
        end else begin
            connect_meta <= connect;
            connect_sync <= connect_meta;
        end
    end

    // receive: a change of data/address restarts the word
    always_ff @(posedge serial_bit_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift        <= '0;
            bit_cnt      <= '0;
            phase        <= sthc_ph_data;
            word         <= '0;
            word_is_addr <= 1'b0;
            word_toggle  <= 1'b0;
        end else if (controller_slot_sel_n) begin
            phase <= board_data_addr_sel ? sthc_ph_addr : sthc_ph_data;
            if ((board_data_addr_sel ? sthc_ph_addr : sthc_ph_data)
                    != phase) begin
                shift   <= {{(DATA_W-1){1'b0}}, serial_in_tap};
                bit_cnt <= 3'h1;
            end else begin
                shift   <= {shift[DATA_W-2:0], serial_in_tap};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == LINK_CNT_LAST) begin
                    word         <= {shift[DATA_W-2:0], serial_in_tap};
                    word_is_addr <= board_data_addr_sel;
                    word_toggle  <= ~word_toggle;
                end
            end
        end
    end

    // transmit readback msb first on the same clock
    always_ff @(posedge serial_bit_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx                <= '0;
            serial_out_tap    <= 1'b0;
            serial_out_tap_oe <= 1'b0;
        end else begin
            tx <= (bit_cnt == 3'h0) ? readback : {tx[DATA_W-2:0], 1'b0};
            serial_out_tap    <= tx[DATA_W-1];
            serial_out_tap_oe <= connect_sync && controller_slot_sel_n
                                 && !board_data_addr_sel;
        end
    end

    chk_slot_ignored: assert property (
        @(posedge serial_bit_clk) disable iff (!rst_n)
        !controller_slot_sel_n |=> $stable(word_toggle) && $stable(word))
        else $error("slot 0 traffic changed the received word");

    chk_serial_float: assert property (
        @(posedge serial_bit_clk) disable iff (!rst_n)
        !connect_sync |=> !serial_out_tap_oe)
        else $error("serial output driven without its connection");
endmodule

// ### rtl/sthc_top.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - with scanning on, the eight channels reach the main output in turn.
// - with scanning off, the main output selection stays on channel 0.
// - channels 1 to 7 always drive their own dedicated outputs.
// - with scanning on, each scan clock pulse from the board advances to the next channel.
// - when driven, track/hold status is low tracking and high holding.
// - track/hold status may be programmed to float instead.
// - hold trigger pin is programmable as input or as output.
// - an asserted hold trigger moves the module from track to hold.
// - data/address select marks serial words; data and address act differently.
// - traffic marked for slot 0 is ignored by the module.
// - the serial clock times every bit in and every bit out.
// - serial output is driven only when its connection is selected.
module sthc_top (
    // system
    input  wire logic                        clock,
    input  wire logic                        rstn,
    // register port
    input  wire logic [sthc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sthc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    output logic      [sthc_pkg::DATA_W-1:0] reg_rdata,
    // scan
    input  wire logic                        channel_advance_clk,
    output logic      [sthc_pkg::CHAN_N-1:0] main_out_sel,
    output logic      [sthc_pkg::CHAN_N-2:0] per_channel_out,
    // track and hold
    output logic                             holding_mode,
    output logic                             track_hold_status,
    output logic                             track_hold_status_oe,
    input  wire logic                        hold_trigger_pin_in,
    output logic                             hold_trigger_pin_out,
    output logic                             hold_trigger_pin_oe,
    // serial link
    input  wire logic                        serial_bit_clk,
    input  wire logic                        serial_in_tap,
    input  wire logic                        board_data_addr_sel,
    input  wire logic                        controller_slot_sel_n,
    output logic                             serial_out_tap,
    output logic                             serial_out_tap_oe
);
    import sthc_pkg::*;

    function automatic logic [CHAN_N-1:0] one_hot(
        input logic [CHAN_W-1:0] chan
    );
        logic [CHAN_N-1:0] v;
        v = '0;
        v[chan] = 1'b1;
        return v;
    endfunction

    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        return addr == offset;
    endfunction

    logic              rst_meta;
    logic              rst_n;
    logic [CTRL_W-1:0] ctrl;
    logic [CHAN_W-1:0] channel;
    logic [CHAN_W-1:0] next_channel;
    logic              adv_meta;
    logic              adv_sync;
    logic              adv_last;
    logic              adv_rise;
    logic              trig_meta;
    logic              trig_sync;
    logic              trig_last;
    logic              trig_rise;
    logic              holding;
    logic              release_cmd;
    logic              ctrl_write;
    logic              selected;
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] readback;
    logic [DATA_W-1:0] link_word;
    logic              link_is_addr;
    logic              link_toggle;
    logic              tog_meta;
    logic              tog_sync;
    logic              tog_last;
    logic              word_evt;

    // reset release through two flip-flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pin synchronisers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            adv_meta  <= 1'b0;
            adv_sync  <= 1'b0;
            adv_last  <= 1'b0;
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_last <= 1'b0;
            tog_meta  <= 1'b0;
            tog_sync  <= 1'b0;
            tog_last  <= 1'b0;
        end else begin
            adv_meta  <= channel_advance_clk;
            adv_sync  <= adv_meta;
            adv_last  <= adv_sync;
            trig_meta <= hold_trigger_pin_in;
            trig_sync <= trig_meta;
            trig_last <= trig_sync;
            tog_meta  <= link_toggle;
            tog_sync  <= tog_meta;
            tog_last  <= tog_sync;
        end
    end

    assign adv_rise    = adv_sync && !adv_last;
    assign trig_rise   = trig_sync && !trig_last && !ctrl[CTRL_TRIG_OUT];
    assign word_evt    = tog_sync ^ tog_last;
    assign ctrl_write  = reg_write && reg_hit(reg_addr, REG_CTRL);
    assign release_cmd = reg_write && reg_hit(reg_addr, REG_COMMAND)
                         && reg_wdata[CMD_RELEASE];

    // channel sequencing
    always_comb begin
        if (!ctrl[CTRL_SCAN_EN]) begin
            next_channel = CHAN_FIRST;
        end else if (adv_rise) begin
            if (channel == CHAN_LAST) begin
                next_channel = CHAN_FIRST;
            end else begin
                next_channel = channel + 3'h1;
            end
        end else begin
            next_channel = channel;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            channel      <= CHAN_FIRST;
            main_out_sel <= 8'h01;
        end else begin
            channel      <= next_channel;
            main_out_sel <= one_hot(next_channel);
        end
    end

    // dedicated channel outputs stay enabled
    genvar g;
    generate
        for (g = 0; g < CHAN_N - 1; g++) begin : gen_per_chan
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    per_channel_out[g] <= PER_CHAN_ON[g];
                end else begin
                    per_channel_out[g] <= PER_CHAN_ON[g];
                end
            end
        end
    endgenerate

    // control register: software write wins over a serial data word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= reg_wdata[CTRL_W-1:0];
        end else if (word_evt && !link_is_addr && selected) begin
            ctrl <= link_word[CTRL_W-1:0];
        end
    end

    // serial words: address selects the module, data is stored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            selected <= 1'b0;
            rx_data  <= '0;
            readback <= '0;
        end else begin
            if (word_evt) begin
                if (link_is_addr) begin
                    selected <= (link_word == MODULE_ADDR);
                end else if (selected) begin
                    rx_data <= link_word;
                end
                readback <= {3'h0, selected, holding, channel};
            end
        end
    end

    // hold state: in output mode follows the hold request, else trigger sets, release clears, set wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            holding <= 1'b0;
        end else if (ctrl[CTRL_TRIG_OUT]) begin
            holding <= ctrl[CTRL_HOLD_REQ];
        end else if (trig_rise) begin
            holding <= 1'b1;
        end else if (release_cmd) begin
            holding <= 1'b0;
        end
    end

    // pin drivers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            holding_mode         <= 1'b0;
            track_hold_status    <= 1'b0;
            track_hold_status_oe <= 1'b0;
            hold_trigger_pin_out <= 1'b0;
            hold_trigger_pin_oe  <= 1'b0;
        end else begin
            holding_mode         <= holding;
            track_hold_status    <= holding;
            track_hold_status_oe <= ctrl[CTRL_STATUS_DRIVE];
            hold_trigger_pin_out <= ctrl[CTRL_HOLD_REQ];
            hold_trigger_pin_oe  <= ctrl[CTRL_TRIG_OUT];
        end
    end

    // read data one cycle after the read strobe, zero otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CTRL: begin
                    reg_rdata <= {3'h0, ctrl};
                end
                REG_STATUS: begin
                    reg_rdata <= {3'h0, selected, holding, channel};
                end
                REG_RX_DATA: begin
                    reg_rdata <= rx_data;
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    sthc_link u_link (
        .serial_bit_clk        (serial_bit_clk),
        .rst_n                 (rst_n),
        .serial_in_tap         (serial_in_tap),
        .board_data_addr_sel   (board_data_addr_sel),
        .controller_slot_sel_n (controller_slot_sel_n),
        .serial_out_tap        (serial_out_tap),
        .serial_out_tap_oe     (serial_out_tap_oe),
        .connect               (ctrl[CTRL_SER_CONNECT]),
        .readback              (readback),
        .word                  (link_word),
        .word_is_addr          (link_is_addr),
        .word_toggle           (link_toggle)
    );

    chk_scan_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl[CTRL_SCAN_EN] && adv_rise && channel != CHAN_LAST
        |=> channel == $past(channel) + 3'h1)
        else $error("scan did not step to the next channel");

    chk_scan_wrap: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl[CTRL_SCAN_EN] && adv_rise && channel == CHAN_LAST
        |=> channel == CHAN_FIRST && main_out_sel == 8'h01)
        else $error("scan did not wrap to channel zero");

    chk_noscan_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ctrl[CTRL_SCAN_EN] |=> main_out_sel == 8'h01)
        else $error("main output left channel 0 while not scanning");

    chk_scan_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !adv_rise |=> $stable(channel) || channel == CHAN_FIRST)
        else $error("channel moved without a scan clock pulse");

    chk_pin_edge: assert property (
        @(posedge clock) disable iff (!rst_n)
        !channel_advance_clk ##1 channel_advance_clk |-> ##2 adv_rise)
        else $error("scan clock pulse not seen two cycles after its edge");

    chk_per_chan_on: assert property (
        @(posedge clock) disable iff (!rst_n)
        per_channel_out == PER_CHAN_ON)
        else $error("dedicated channel output disabled");

    chk_status_level: assert property (
        @(posedge clock) disable iff (!rst_n)
        track_hold_status_oe |-> track_hold_status == $past(holding))
        else $error("track/hold status does not follow hold state");

    chk_status_float: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ctrl[CTRL_STATUS_DRIVE] |=> !track_hold_status_oe)
        else $error("track/hold status driven while set to float");

    chk_trig_dir: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl[CTRL_TRIG_OUT] ##1 ctrl[CTRL_TRIG_OUT]
        |-> hold_trigger_pin_oe
            && hold_trigger_pin_out == $past(ctrl[CTRL_HOLD_REQ]))
        else $error("hold trigger not driven in output mode");

    chk_hold_enter: assert property (
        @(posedge clock) disable iff (!rst_n)
        trig_rise |=> holding ##1 holding_mode)
        else $error("hold trigger did not enter hold mode");

    chk_sel_onehot: assert property (
        @(posedge clock) disable iff (!rst_n)
        $onehot(main_out_sel) && main_out_sel == one_hot(channel))
        else $error("main output selection is not the current channel");

    chk_status_drive: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl[CTRL_STATUS_DRIVE] |=> track_hold_status_oe)
        else $error("track/hold status not driven when programmed");

    chk_trig_input: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ctrl[CTRL_TRIG_OUT] |=> !hold_trigger_pin_oe)
        else $error("hold trigger pin driven in input mode");

    chk_addr_word: assert property (
        @(posedge clock) disable iff (!rst_n)
        word_evt && link_is_addr && !ctrl_write |=> $stable(ctrl))
        else $error("address word changed the control register");
endmodule

// ### shared/sthc_pkg.sv
package sthc_pkg;
    // register port widths, channel width and count
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CTRL_W = 5;
    localparam int CHAN_W = 3;
    localparam int CHAN_N = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h1;
    localparam logic [ADDR_W-1:0] REG_RX_DATA = 4'h2;
    localparam logic [ADDR_W-1:0] REG_COMMAND = 4'h3;

    // control register fields
    localparam int CTRL_SCAN_EN      = 0;
    localparam int CTRL_STATUS_DRIVE = 1;
    localparam int CTRL_TRIG_OUT     = 2;
    localparam int CTRL_SER_CONNECT  = 3;
    localparam int CTRL_HOLD_REQ     = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // command register fields
    localparam int CMD_RELEASE = 0;

    // status register fields
    localparam int STAT_CHAN_LSB = 0;
    localparam int STAT_HOLDING  = 3;
    localparam int STAT_SELECTED = 4;

    // channel numbers
    localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;
    localparam logic [CHAN_W-1:0] CHAN_LAST  = 3'h7;
    localparam logic [CHAN_N-2:0] PER_CHAN_ON = 7'h7f;

    // serial link word
    localparam int LINK_BITS = 8;
    localparam logic [2:0] LINK_CNT_LAST = 3'h7;
    // module address on the serial link; value is arbitrary
    localparam logic [DATA_W-1:0] MODULE_ADDR = 8'h01;

    typedef enum logic [0:0] {
        sthc_ph_data = 1'b0,
        sthc_ph_addr = 1'b1
    } sthc_phase_type;
endpackage

// ### testbench/sthc_board_model.sv
`timescale 1ns/1ps
module sthc_board_model (
    // scan line
    output logic channel_advance_clk,
    // serial link lines
    output logic serial_bit_clk,
    output logic serial_in_tap,
    output logic board_data_addr_sel,
    output logic controller_slot_sel_n
);
    initial begin
        channel_advance_clk   = 1'b0;
        serial_bit_clk        = 1'b0;
        serial_in_tap         = 1'b0;
        board_data_addr_sel   = 1'b0;
        controller_slot_sel_n = 1'b1;
    end

    // one sample taken: scan clock high then low, off the clock edges
    task automatic scan_pulse();
        #325 channel_advance_clk = 1'b1;
        #350 channel_advance_clk = 1'b0;
    endtask

    // one word, msb first; the link clock stands still outside the frame
    task automatic send_word(input logic       is_addr,
                             input logic       slot_n,
                             input logic [7:0] value);
        int i;
        board_data_addr_sel   = is_addr;
        controller_slot_sel_n = slot_n;
        for (i = 7; i >= 0; i--) begin
            serial_in_tap = value[i];
            #62.5 serial_bit_clk = 1'b1;
            #62.5 serial_bit_clk = 1'b0;
        end
        // released data line must not keep showing the last bit
        serial_in_tap = ~value[0];
    endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import sthc_pkg::*;
    logic                clock;
    logic                rstn;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic [DATA_W-1:0]   reg_rdata;
    logic                reg_write;
    logic                reg_read;
    logic                channel_advance_clk;
    logic [CHAN_N-1:0]   main_out_sel;
    logic [CHAN_N-2:0]   per_channel_out;
    logic                holding_mode;
    logic                track_hold_status;
    logic                track_hold_status_oe;
    logic                trig_drive;
    logic                hold_trigger_pin_in;
    logic                hold_trigger_pin_out;
    logic                hold_trigger_pin_oe;
    logic                serial_bit_clk;
    logic                serial_in_tap;
    logic                board_data_addr_sel;
    logic                controller_slot_sel_n;
    logic                serial_out_tap;
    logic                serial_out_tap_oe;
    logic                oe_seen;
    logic [7:0]          out_bits;
    int                  mismatches;
    int                  check_count;
    int                  i;

    // trigger pin level seen by everyone on the wire
    assign hold_trigger_pin_in = hold_trigger_pin_oe ? hold_trigger_pin_out
                                                     : trig_drive;

    sthc_top dut (
        .clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .channel_advance_clk, .main_out_sel, .per_channel_out,
        .holding_mode, .track_hold_status, .track_hold_status_oe,
        .hold_trigger_pin_in, .hold_trigger_pin_out, .hold_trigger_pin_oe,
        .serial_bit_clk, .serial_in_tap, .board_data_addr_sel,
        .controller_slot_sel_n, .serial_out_tap, .serial_out_tap_oe
    );

    sthc_board_model board (
        .channel_advance_clk, .serial_bit_clk, .serial_in_tap,
        .board_data_addr_sel, .controller_slot_sel_n
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(negedge serial_bit_clk) begin
        if (serial_out_tap_oe === 1'b1) begin
            oe_seen  = 1'b1;
            out_bits = {out_bits[6:0], serial_out_tap};
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, want);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] want);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        check(reg_rdata, want);
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rstn       = 1'b0;
        reg_addr   = '0;
        reg_wdata  = '0;
        reg_write  = 1'b0;
        reg_read   = 1'b0;
        trig_drive = 1'b0;
        oe_seen    = 1'b0;
        out_bits   = '0;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        idle(3);
        check(main_out_sel, 8'h01);
        check({1'b0, per_channel_out}, 8'h7f);
        check(track_hold_status_oe, 1'b0);
        check(serial_out_tap_oe, 1'b0);
        reg_rd(REG_CTRL, 8'h00);
        reg_rd(4'hf, 8'h00);
        board.scan_pulse();
        idle(6);
        check(main_out_sel, 8'h01);
        // scan through all channels and past the wrap
        reg_wr(REG_CTRL, 8'h01);
        for (i = 1; i <= 8; i++) begin
            board.scan_pulse();
            idle(6);
            check(main_out_sel, 8'h01 << (i % 8));
            reg_rd(REG_STATUS, 8'(i % 8));
            check({1'b0, per_channel_out}, 8'h7f);
        end
        board.scan_pulse();
        reg_wr(REG_CTRL, 8'h00);
        idle(6);
        check(main_out_sel, 8'h01);
        // trigger pin as input, status pin driven
        reg_wr(REG_CTRL, 8'h02);
        idle(3);
        check(track_hold_status_oe, 1'b1);
        check(track_hold_status, 1'b0);
        @(posedge clock);
        trig_drive <= 1'b1;
        idle(8);
        check(holding_mode, 1'b1);
        check(track_hold_status, 1'b1);
        reg_rd(REG_STATUS, 8'h08);
        @(posedge clock);
        trig_drive <= 1'b0;
        reg_wr(REG_COMMAND, 8'h01);
        idle(4);
        check(holding_mode, 1'b0);
        check(track_hold_status, 1'b0);
        reg_wr(REG_CTRL, 8'h00);
        idle(3);
        check(track_hold_status_oe, 1'b0);
        // trigger pin as output with hold requested
        reg_wr(REG_CTRL, 8'h14);
        idle(3);
        check(hold_trigger_pin_oe, 1'b1);
        check(hold_trigger_pin_out, 1'b1);
        check(holding_mode, 1'b1);
        reg_wr(REG_CTRL, 8'h04);
        idle(3);
        check(hold_trigger_pin_out, 1'b0);
        check(holding_mode, 1'b0);
        reg_wr(REG_CTRL, 8'h00);
        idle(3);
        check(hold_trigger_pin_oe, 1'b0);
        // serial link: select, data word, slot 0 traffic, deselect
        reg_wr(REG_CTRL, 8'h08);
        board.send_word(1'b1, 1'b1, MODULE_ADDR);
        idle(8);
        reg_rd(REG_STATUS, 8'h10);
        oe_seen = 1'b0;
        board.send_word(1'b0, 1'b1, 8'h0a);
        idle(8);
        reg_rd(REG_RX_DATA, 8'h0a);
        reg_rd(REG_CTRL, 8'h0a);
        check(oe_seen, 1'b1);
        check(track_hold_status_oe, 1'b1);
        // readback 8'h10 (selected) leaves one edge late: one place down
        out_bits = '0;
        board.send_word(1'b0, 1'b1, 8'h0a);
        idle(8);
        check({1'b0, out_bits[6:0]}, 8'h08);
        board.send_word(1'b0, 1'b0, 8'h01);
        idle(8);
        reg_rd(REG_RX_DATA, 8'h0a);
        reg_rd(REG_CTRL, 8'h0a);
        board.send_word(1'b1, 1'b1, 8'h02);
        idle(8);
        reg_rd(REG_STATUS, 8'h00);
        board.send_word(1'b0, 1'b1, 8'h03);
        idle(8);
        reg_rd(REG_RX_DATA, 8'h0a);
        // serial out left undriven when not connected
        reg_wr(REG_CTRL, 8'h00);
        idle(4);
        board.send_word(1'b1, 1'b1, MODULE_ADDR);
        oe_seen = 1'b0;
        board.send_word(1'b0, 1'b1, 8'h00);
        idle(8);
        check(oe_seen, 1'b0);
        report_and_stop();
    end
endmodule
